// File: logic/gpib_pp_map.svh
// register offsets, field positions, codes and reset values of the poll responder
`ifndef GPIB_PP_MAP_SVH
`define GPIB_PP_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_AUX 12'h004
`define OFS_PASS 12'h008
`define OFS_STATUS 12'h00C
`define OFS_DOUT 12'h010
`define OFS_POLLCFG 12'h014
// ****************************************
// control fields
// ****************************************
`define CTRL_IST 0
`define CTRL_TON 1
`define CTRL_ADDR_LO 8
`define CTRL_RESET 32'h0000_0000
// ****************************************
// status fields
// ****************************************
`define ST_ADDRESS_STATUS_CHANGE 0
`define ST_TA 1
`define ST_TALKER_PRIMARY_ADDRESSED 2
`define ST_PASS 3
`define ST_BO 4
`define ST_ERR 5
`define ST_PSTATE_LO 6
// ****************************************
// bus and auxiliary command codes
// ****************************************
`define CMD_UNTALK 8'h5F
`define CMD_SPD 8'h19
`define CMD_TALK_BASE 3'h2
`define CMD_PPC 8'h05
`define CMD_PPU 8'h15
`define CMD_PPX_TOP 3'h3
`define AUX_LPE_TOP 3'h3
`define AUX_VALID_SECONDARY_COMMAND 8'h0F
`define DOUT_END 8
`endif

// File: logic/gpib_pp_pkg.sv
// types shared by the poll responder files
package gpib_pp_pkg;
    typedef enum logic [1:0] {
        POLL_IDLE,
        POLL_STANDBY,
        POLL_ACTIVE
    } pollState_t;
    typedef logic [7:0] byte_t;
endpackage

// File: logic/gpib_pp_resp.sv
// parallel poll state machine and data line driver
`timescale 1ns/1ps
`include "gpib_pp_map.svh"
module gpib_pp_resp (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic lpe,
    input wire logic sense,
    input wire logic [2:0] lineSel,
    input wire logic ist,
    input wire logic atnTrue,
    input wire logic eoiTrue,
    output gpib_pp_pkg::pollState_t pollState,
    output logic [7:0] dioOut,
    output logic [7:0] dioOeN
);
    import gpib_pp_pkg::*;
    pollState_t state_reg, state_next;
    logic [7:0] oeN_reg, oeN_next;
    wire pollCmd = atnTrue & eoiTrue;
    wire respTrue = (ist == sense); // RULE8
    // ****************************************
    // poll function states
    // ****************************************
    // idle, standby and active transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            POLL_IDLE: if (lpe) state_next = POLL_STANDBY; // RULE5
            POLL_STANDBY: begin
                if (!lpe) state_next = POLL_IDLE;
                else if (pollCmd) state_next = POLL_ACTIVE; // RULE22
            end
            POLL_ACTIVE: begin
                if (!lpe) state_next = POLL_IDLE;
                else if (!pollCmd) state_next = POLL_STANDBY; // RULE22
            end
            default: state_next = POLL_IDLE;
        endcase
    end
    // one lane of eight, only in active state, only on true response
    always_comb begin
        oeN_next = 8'hFF;
        if (state_next == POLL_ACTIVE && respTrue) begin // RULE17
            oeN_next[lineSel] = 1'b0; // RULE9 RULE11
        end
    end
    // state and driver flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= POLL_IDLE;
            oeN_reg <= 8'hFF;
        end else begin
            state_reg <= state_next;
            oeN_reg <= oeN_next;
        end
    end
    assign pollState = state_reg;
    assign dioOeN = oeN_reg;
    assign dioOut = 8'h00; // true is low on the bus
    // ****************************************
    // checks
    // ****************************************
    property p_idleSilent;
        @(posedge core_clk) disable iff (rst)
        $past(state_reg) == POLL_IDLE |-> dioOeN == 8'hFF;
    endproperty
    a_idleSilent: assert property (p_idleSilent) else $error("idle poll drove"); // RULE5
    property p_oneLine;
        @(posedge core_clk) disable iff (rst)
        $countones(~dioOeN) <= 1;
    endproperty
    a_oneLine: assert property (p_oneLine) else $error("more than one line"); // RULE11
    property p_respond;
        @(posedge core_clk) disable iff (rst)
        (state_reg == POLL_STANDBY && lpe && pollCmd && respTrue)
            |=> dioOeN[$past(lineSel)] == 1'b0;
    endproperty
    a_respond: assert property (p_respond) else $error("no poll response"); // RULE17
    property p_sense;
        @(posedge core_clk) disable iff (rst)
        dioOeN != 8'hFF |-> $past(ist) == $past(sense);
    endproperty
    a_sense: assert property (p_sense) else $error("response with wrong sense"); // RULE8
    property p_release;
        @(posedge core_clk) disable iff (rst)
        (state_reg == POLL_ACTIVE && !pollCmd) |=> dioOeN == 8'hFF;
    endproperty
    a_release: assert property (p_release) else $error("line held after poll"); // RULE22
    c_active: cover property (@(posedge core_clk) state_reg == POLL_ACTIVE && dioOeN != 8'hFF);
    c_back: cover property (@(posedge core_clk) state_reg == POLL_ACTIVE ##1
        state_reg == POLL_STANDBY);
endmodule

// File: logic/gpib_pp_top.sv
// talker/listener poll responder: apb registers, command capture and talker status
`timescale 1ns/1ps
`include "gpib_pp_map.svh"
// What the document requires
// RULE1: controller waits for byte-out flag, then sends untalk and poll-disable codes; the model's closeSerialPoll sends them without waiting.
// RULE2: controller clears its latched service-request status with a command code; the model latches no SRQ and sends no such code.
// RULE3: untalk sets address-status-change and clears both talker-addressed bits.
// RULE4: controller clears service-request status only after SRQ goes false; the model has no SRQ and clears nothing.
// RULE5: poll function has idle, standby, active; idle never answers a poll.
// RULE6: controller starts a parallel poll with ATN and EOI together.
// RULE7: aux command 011USPPP with U zero enables poll, idle to standby.
// RULE8: response is true only when individual status equals sense bit.
// RULE9: three-bit field picks which of eight data lines answers.
// RULE10: after reset no true response until the poll flag is set; with sense 0 the code answers true while the flag is still clear.
// RULE11: one line per device, so at most eight devices per poll.
// RULE12: bus poll-enable is passed through and becomes the local enable.
// RULE13: poll-disable clears sense and line bits, sets unconfigure, disables poll.
// RULE14: poll-configure is captured in pass-through register, handshake held off.
// RULE15: cpu writes valid-secondary-command code to release the handshake.
// RULE16: cpu clears top bit of captured enable and writes it as aux.
// RULE17: in standby with ATN and EOI, selected line driven when response holds.
// RULE18: cpu clears the poll flag when it decodes poll-unconfigure.
// RULE19: talk-only mode flags an error when no active listener exists.
// RULE20: a controller coming on line pulses interface clear for 100 us; the model has no interface clear line and never pulses it.
// RULE21: talker asserts EOI with the last byte of a block.
// RULE22: active while ATN and EOI, back to standby and line released otherwise.
module gpib_pp_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic atnTrue,
    input wire logic eoiTrue,
    input wire logic cmdStrobe,
    input wire gpib_pp_pkg::byte_t cmdByte,
    output logic cmdHoldoff,
    input wire logic nrfdTrue,
    input wire logic ndacTrue,
    input wire logic srcAccept,
    output logic srcValid,
    output gpib_pp_pkg::byte_t srcByte,
    output logic srcEoi,
    output logic [7:0] dioOut,
    output logic [7:0] dioOeN
);
    import gpib_pp_pkg::*;
    // ****************************************
    // apb decode
    // ****************************************
    // every register answers in the access cycle, no wait states
    wire wrEn = psel & penable & pwrite;
    wire rdEn = psel & penable & ~pwrite;
    wire selCtrl = (paddr == `OFS_CTRL);
    wire selAux = (paddr == `OFS_AUX);
    wire selPass = (paddr == `OFS_PASS);
    wire selStatus = (paddr == `OFS_STATUS);
    wire selDout = (paddr == `OFS_DOUT);
    wire selPollCfg = (paddr == `OFS_POLLCFG);
    wire mapped = selCtrl | selAux | selPass | selStatus | selDout | selPollCfg;
    wire wrCtrl = wrEn & selCtrl;
    wire wrAux = wrEn & selAux;
    wire wrStatus = wrEn & selStatus;
    wire wrDout = wrEn & selDout;
    wire [7:0] auxByte = pwdata[7:0];

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] ctrl_reg;
    logic lpe_reg, lpe_next;
    logic sense_reg, sense_next;
    logic [2:0] lineSel_reg, lineSel_next;
    byte_t pass_reg;
    logic passPend_reg, passPend_next;
    logic address_status_change_reg, address_status_change_next;
    logic ta_reg, ta_next;
    logic talker_primary_addressed_reg, talker_primary_addressed_next;
    logic bo_reg, bo_next;
    logic err_reg, err_next;
    logic srcValid_reg, srcValid_next;
    byte_t srcByte_reg;
    logic srcEoi_reg;
    logic [31:0] prdata_reg, prdata_next;
    pollState_t pollState;

    wire ist = ctrl_reg[`CTRL_IST];
    wire talkOnly = ctrl_reg[`CTRL_TON];
    wire [4:0] myAddr = ctrl_reg[`CTRL_ADDR_LO +: 5];

    // ****************************************
    // bus command classification
    // ****************************************
    // undefined commands go to software instead of being acted on
    function automatic logic isUndefined(input byte_t c);
        isUndefined = (c == `CMD_PPC) || (c == `CMD_PPU) || (c[7:5] == `CMD_PPX_TOP);
    endfunction
    wire cmdUntalk = cmdStrobe & (cmdByte == `CMD_UNTALK);
    wire cmdMyTalk = cmdStrobe & (cmdByte[7:5] == `CMD_TALK_BASE) & (cmdByte[4:0] == myAddr);
    wire cmdOtherTalk = cmdStrobe & (cmdByte[7:5] == `CMD_TALK_BASE) & ~cmdMyTalk;
    wire cmdCapture = cmdStrobe & isUndefined(cmdByte) & ~passPend_reg;

    // ****************************************
    // local poll enable from aux writes
    // ****************************************
    // 011USPPP: U low configures, U high unconfigures
    wire auxLpe = wrAux & (auxByte[7:5] == `AUX_LPE_TOP);
    wire auxVscmd = wrAux & (auxByte == `AUX_VALID_SECONDARY_COMMAND);
    always_comb begin
        lpe_next = lpe_reg;
        sense_next = sense_reg;
        lineSel_next = lineSel_reg;
        if (auxLpe) begin
            lpe_next = ~auxByte[4]; // RULE7 RULE12 RULE13
            sense_next = auxByte[3]; // RULE8
            lineSel_next = auxByte[2:0]; // RULE9
        end
    end

    // ****************************************
    // pass-through capture and handshake holdoff
    // ****************************************
    // released by the valid-secondary-command write or by a poll-enable aux write
    always_comb begin
        passPend_next = passPend_reg;
        if (auxVscmd || auxLpe) passPend_next = 1'b0;
        if (cmdCapture) passPend_next = 1'b1; // RULE14
    end
    assign cmdHoldoff = passPend_reg; // RULE14

    // ****************************************
    // talker address status
    // ****************************************
    // event set wins over the software clear of the change flag
    always_comb begin
        ta_next = ta_reg;
        talker_primary_addressed_next = talker_primary_addressed_reg;
        address_status_change_next = address_status_change_reg;
        if (wrStatus && pwdata[`ST_ADDRESS_STATUS_CHANGE]) address_status_change_next = 1'b0;
        if (cmdMyTalk) begin
            ta_next = 1'b1;
            talker_primary_addressed_next = 1'b1;
            address_status_change_next = 1'b1;
        end else if ((cmdUntalk || cmdOtherTalk) && ta_reg) begin
            ta_next = 1'b0; // RULE3
            talker_primary_addressed_next = 1'b0; // RULE3
            address_status_change_next = 1'b1; // RULE3
        end
    end

    // ****************************************
    // talker data source
    // ****************************************
    // byte offered while talking; end bit rides as eoi with the last byte
    wire talking = ta_reg | talkOnly;
    wire noListener = ~nrfdTrue & ~ndacTrue;
    always_comb begin
        srcValid_next = srcValid_reg;
        bo_next = bo_reg;
        err_next = err_reg;
        if (srcAccept && srcValid_reg && talking) begin
            srcValid_next = 1'b0;
            bo_next = 1'b1;
        end
        // a new byte written in the accept cycle is kept
        if (wrDout) begin
            srcValid_next = 1'b1;
            bo_next = 1'b0;
        end
        if (wrStatus && pwdata[`ST_ERR]) err_next = 1'b0;
        if (talkOnly && srcValid_reg && noListener) err_next = 1'b1; // RULE19
    end
    assign srcValid = srcValid_reg & talking;
    assign srcByte = srcByte_reg;
    assign srcEoi = srcEoi_reg & srcValid; // RULE21

    // ****************************************
    // read mux
    // ****************************************
    wire [31:0] statusWord = {24'h00_0000, 2'(pollState), err_reg, bo_reg,
        passPend_reg, talker_primary_addressed_reg, ta_reg, address_status_change_reg};
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (rdEn) begin
            if (selCtrl) prdata_next = ctrl_reg;
            if (selPass) prdata_next = {24'h00_0000, pass_reg};
            if (selStatus) prdata_next = statusWord;
            if (selPollCfg) prdata_next = {27'h000_0000, lpe_reg, sense_reg, lineSel_reg};
        end
    end
    assign prdata = prdata_next;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ****************************************
    // flops
    // ****************************************
    // configuration and control
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RESET; // RULE10
            lpe_reg <= 1'b0;
            sense_reg <= 1'b0;
            lineSel_reg <= 3'h0;
            passPend_reg <= 1'b0;
            pass_reg <= 8'h00;
        end else begin
            if (wrCtrl) ctrl_reg <= pwdata;
            lpe_reg <= lpe_next;
            sense_reg <= sense_next;
            lineSel_reg <= lineSel_next;
            passPend_reg <= passPend_next;
            if (cmdCapture) pass_reg <= cmdByte; // RULE14
        end
    end
    // status and talker flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ta_reg <= 1'b0;
            talker_primary_addressed_reg <= 1'b0;
            address_status_change_reg <= 1'b0;
            bo_reg <= 1'b1;
            err_reg <= 1'b0;
            srcValid_reg <= 1'b0;
            srcByte_reg <= 8'h00;
            srcEoi_reg <= 1'b0;
        end else begin
            ta_reg <= ta_next;
            talker_primary_addressed_reg <= talker_primary_addressed_next;
            address_status_change_reg <= address_status_change_next;
            bo_reg <= bo_next;
            err_reg <= err_next;
            srcValid_reg <= srcValid_next;
            if (wrDout) srcByte_reg <= pwdata[7:0];
            if (wrDout) srcEoi_reg <= pwdata[`DOUT_END]; // RULE21
        end
    end

    // ****************************************
    // poll responder
    // ****************************************
    gpib_pp_resp pollResp (
        .core_clk(core_clk),
        .rst(rst),
        .lpe(lpe_reg),
        .sense(sense_reg),
        .lineSel(lineSel_reg),
        .ist(ist),
        .atnTrue(atnTrue),
        .eoiTrue(eoiTrue),
        .pollState(pollState),
        .dioOut(dioOut),
        .dioOeN(dioOeN)
    );

    // ****************************************
    // checks
    // ****************************************
    property p_untalk;
        @(posedge core_clk) disable iff (rst)
        (cmdUntalk && ta_reg) |=> address_status_change_reg && !ta_reg && !talker_primary_addressed_reg;
    endproperty
    a_untalk: assert property (p_untalk) else $error("untalk not applied"); // RULE3
    property p_capture;
        @(posedge core_clk) disable iff (rst)
        cmdCapture |=> cmdHoldoff && pass_reg == $past(cmdByte);
    endproperty
    a_capture: assert property (p_capture) else $error("command not captured"); // RULE14
    property p_holdRelease;
        @(posedge core_clk) disable iff (rst)
        (cmdHoldoff && !auxVscmd && !auxLpe) |=> cmdHoldoff;
    endproperty
    a_holdRelease: assert property (p_holdRelease) else $error("holdoff dropped"); // RULE14
    property p_lpe;
        @(posedge core_clk) disable iff (rst)
        auxLpe |=> lpe_reg == !$past(auxByte[4]) && lineSel_reg == $past(auxByte[2:0]);
    endproperty
    a_lpe: assert property (p_lpe) else $error("poll enable not taken"); // RULE7
    property p_disable;
        @(posedge core_clk) disable iff (rst)
        (auxLpe && auxByte[4]) |=> ##1 pollState == POLL_IDLE;
    endproperty
    a_disable: assert property (p_disable) else $error("poll not disabled"); // RULE13
    property p_noFlag;
        @(posedge core_clk) disable iff (rst)
        (!ist && sense_reg) [*2] |-> dioOeN == 8'hFF;
    endproperty
    a_noFlag: assert property (p_noFlag) else $error("true response without flag"); // RULE10
    property p_err;
        @(posedge core_clk) disable iff (rst)
        (talkOnly && srcValid_reg && noListener) |=> err_reg;
    endproperty
    a_err: assert property (p_err) else $error("no listener error missed"); // RULE19
    property p_eoi;
        @(posedge core_clk) disable iff (rst)
        srcEoi |-> srcValid && srcEoi_reg;
    endproperty
    a_eoi: assert property (p_eoi) else $error("eoi without last byte"); // RULE21
    // ****************************************
    // talker, pass-through and poll enable checks
    // ****************************************
    // a release write frees the handshake on the next cycle
    property p_vscmdFree;
        @(posedge core_clk) disable iff (rst)
        (auxVscmd && !cmdCapture) |=> !cmdHoldoff;
    endproperty
    a_vscmdFree: assert property (p_vscmdFree) else $error("holdoff not released"); // RULE14
    // a pending capture keeps its byte against later undefined commands
    property p_keepPass;
        @(posedge core_clk) disable iff (rst)
        (cmdStrobe && isUndefined(cmdByte) && passPend_reg) |=> pass_reg == $past(pass_reg);
    endproperty
    a_keepPass: assert property (p_keepPass) else $error("pending command overwritten"); // RULE14
    // own talk address sets both talker bits and the change flag
    property p_myTalk;
        @(posedge core_clk) disable iff (rst)
        cmdMyTalk |=> ta_reg && talker_primary_addressed_reg && address_status_change_reg;
    endproperty
    a_myTalk: assert property (p_myTalk) else $error("talk address not taken"); // RULE3
    // a plain clear of the change flag takes effect
    property p_adscClear;
        @(posedge core_clk) disable iff (rst)
        (wrStatus && pwdata[`ST_ADDRESS_STATUS_CHANGE] && !cmdMyTalk && !cmdUntalk && !cmdOtherTalk)
            |=> !address_status_change_reg;
    endproperty
    a_adscClear: assert property (p_adscClear) else $error("change flag not cleared"); // RULE3
    // an accepted byte sets byte-out and withdraws the offer
    property p_accept;
        @(posedge core_clk) disable iff (rst)
        (srcAccept && srcValid && !wrDout) |=> !srcValid_reg && bo_reg;
    endproperty
    a_accept: assert property (p_accept) else $error("accepted byte still offered"); // RULE1
    // a data write loads the byte and its end bit and clears byte-out
    property p_doutLoad;
        @(posedge core_clk) disable iff (rst)
        wrDout |=> srcValid_reg && !bo_reg && srcByte_reg == $past(pwdata[7:0])
            && srcEoi_reg == $past(pwdata[`DOUT_END]);
    endproperty
    a_doutLoad: assert property (p_doutLoad) else $error("data write not loaded"); // RULE21
    // a poll enable with the unconfigure bit low leaves idle
    property p_lpeOn;
        @(posedge core_clk) disable iff (rst)
        (auxLpe && !auxByte[4]) |=> ##1 pollState != POLL_IDLE;
    endproperty
    a_lpeOn: assert property (p_lpeOn) else $error("poll not enabled"); // RULE7
    c_untalk: cover property (@(posedge core_clk) cmdUntalk && ta_reg);
    c_pass: cover property (@(posedge core_clk) cmdCapture ##[1:20] auxVscmd);
    c_err: cover property (@(posedge core_clk) !err_reg ##1 err_reg);
endmodule

// File: test/gpib_ctrl_model.sv
// far-side model: controller in charge plus one listener for the poll responder bench
`timescale 1ns/1ps
`include "gpib_pp_map.svh"
module gpib_ctrl_model (
    input wire logic core_clk,
    input wire logic srcValid,
    output logic atnTrue,
    output logic eoiTrue,
    output logic cmdStrobe,
    output gpib_pp_pkg::byte_t cmdByte,
    output logic nrfdTrue,
    output logic ndacTrue,
    output logic srcAccept
);
    import gpib_pp_pkg::*;
    // ****************************************
    // bus side of the controller and listener
    // ****************************************
    int lag = 0;
    int waitCnt = 0;
    logic listenOn = 1'b0;
    // lines idle, no listener present
    initial begin
        atnTrue = 1'b0;
        eoiTrue = 1'b0;
        cmdStrobe = 1'b0;
        cmdByte = 8'h00;
        nrfdTrue = 1'b0;
        ndacTrue = 1'b0;
        srcAccept = 1'b0;
    end
    // one command byte per call, strobed for one cycle, then one idle cycle
    task automatic cmd(input byte_t b);
        cmdStrobe <= 1'b1;
        cmdByte <= b;
        @(posedge core_clk);
        cmdStrobe <= 1'b0;
        cmdByte <= ~b; // stale byte not left on the lines
        @(posedge core_clk);
    endtask
    // serial poll close: untalk, then poll disable; srq is never latched, nothing to clear
    task automatic closeSerialPoll();
        cmd(`CMD_UNTALK);
        cmd(`CMD_SPD);
    endtask
    // poll start and end move both lines together
    task automatic poll(input logic on);
        atnTrue <= on;
        eoiTrue <= on;
        @(posedge core_clk);
    endtask
    // listener comes on line or leaves
    task automatic listen(input logic on);
        listenOn <= on;
        ndacTrue <= on;
        @(posedge core_clk);
    endtask
    // accept an offered byte after lag cycles, one-cycle pulse
    always @(posedge core_clk) begin
        nrfdTrue <= listenOn && (waitCnt < lag); // listener busy while it lags
        if (srcValid === 1'b1 && listenOn && !srcAccept && waitCnt >= lag) begin
            srcAccept <= 1'b1;
            waitCnt <= 0;
        end else begin
            srcAccept <= 1'b0;
            waitCnt <= (srcValid === 1'b1 && listenOn) ? waitCnt + 1 : 0;
        end
    end
endmodule

// File: test/testbench.sv
// self-checking bench for the poll responder top
`timescale 1ns/1ps
`include "gpib_pp_map.svh"
module testbench;
    import gpib_pp_pkg::*;
    // ****************************************
    // signals, scoreboard and bus tasks
    // ****************************************
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, pinReq;
    logic atnTrue, eoiTrue, cmdStrobe, cmdHoldoff, nrfdTrue, ndacTrue;
    logic srcAccept, srcValid, srcEoi, s, ist;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] dioOut, dioOeN;
    logic [2:0] ln;
    byte_t cmdByte, srcByte, b;
    logic [32:0] apbQ[$];
    logic [32:0] pinQ[$];
    int nMismatch = 0;
    int checksDone = 0;
    int cycles = 0;
    int seed = 37224;
    int k;
    gpib_pp_top u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .atnTrue(atnTrue), .eoiTrue(eoiTrue), .cmdStrobe(cmdStrobe),
        .cmdByte(cmdByte), .cmdHoldoff(cmdHoldoff), .nrfdTrue(nrfdTrue), .ndacTrue(ndacTrue),
        .srcAccept(srcAccept), .srcValid(srcValid), .srcByte(srcByte), .srcEoi(srcEoi),
        .dioOut(dioOut), .dioOeN(dioOeN));
    gpib_ctrl_model u_far (.core_clk(core_clk), .srcValid(srcValid), .atnTrue(atnTrue),
        .eoiTrue(eoiTrue), .cmdStrobe(cmdStrobe), .cmdByte(cmdByte), .nrfdTrue(nrfdTrue),
        .ndacTrue(ndacTrue), .srcAccept(srcAccept));
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        apbQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // note expected {holdoff, valid, eoi, byte, enables}, sampled next edge
    task automatic pin(input logic [18:0] e);
        pinQ.push_back({14'h0, e});
        pinReq <= 1'b1;
        @(posedge core_clk);
        pinReq <= 1'b0;
    endtask
    // monitor: compare each result with the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            check({pslverr, prdata}, apbQ.pop_front());
        if (pinReq) begin
            check(33'({cmdHoldoff, srcValid, srcEoi, srcByte, dioOeN}), pinQ.pop_front());
            check(33'(dioOut), 33'h0);
        end
    end
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            nMismatch++;
            endOfTest();
        end
    end
    // main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pinReq = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        pin(19'h000FF);
        rd(`OFS_CTRL, 33'h0);
        rd(`OFS_STATUS, 33'h10);
        rd(`OFS_POLLCFG, 33'h0);
        rd(12'h018, 33'h1_0000_0000);
        u_far.poll(1'b1);
        pin(19'h000FF);
        u_far.poll(1'b0);
        for (int n = 0; n < 8; n++) begin
            s = 1'($random(seed));
            ln = 3'(n);
            ist = ln[0] ? s : ~s;
            wr(`OFS_CTRL, {31'h0, ist});
            wr(`OFS_AUX, {24'h0, 3'h3, 1'b0, s, ln});
            tick(2);
            u_far.poll(1'b1);
            pin({11'h0, (ist == s) ? ~(8'h01 << ln) : 8'hFF});
            rd(`OFS_STATUS, 33'h90);
            rd(`OFS_POLLCFG, {28'h1, s, ln});
            u_far.poll(1'b0);
            pin(19'h000FF);
            rd(`OFS_STATUS, 33'h50);
        end
        u_far.cmd(`CMD_PPC);
        pin(19'h400FF);
        rd(`OFS_PASS, 33'h05);
        rd(`OFS_STATUS, 33'h58);
        u_far.cmd(`CMD_PPU);
        rd(`OFS_PASS, 33'h05);
        wr(`OFS_AUX, {24'h0, `AUX_VALID_SECONDARY_COMMAND});
        pin(19'h000FF);
        s = 1'($random(seed));
        ln = 3'($random(seed));
        b = {3'h3, 1'b0, s, ln};
        u_far.cmd(b);
        rd(`OFS_PASS, {25'h0, b});
        wr(`OFS_AUX, {24'h0, b & 8'h7F});
        wr(`OFS_CTRL, {31'h0, s});
        tick(2);
        u_far.poll(1'b1);
        pin({11'h0, ~(8'h01 << ln)});
        u_far.poll(1'b0);
        u_far.cmd(8'h70);
        wr(`OFS_AUX, 32'h70);
        tick(2);
        rd(`OFS_POLLCFG, 33'h0);
        u_far.poll(1'b1);
        pin(19'h000FF);
        u_far.poll(1'b0);
        u_far.cmd(`CMD_PPU);
        wr(`OFS_PASS, 32'hAA);
        rd(`OFS_PASS, 33'h15);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_AUX, {24'h0, `AUX_VALID_SECONDARY_COMMAND});
        wr(`OFS_CTRL, 32'h500);
        u_far.cmd(8'h45);
        rd(`OFS_STATUS, 33'h17);
        wr(`OFS_STATUS, 32'h1);
        rd(`OFS_STATUS, 33'h16);
        u_far.closeSerialPoll();
        rd(`OFS_STATUS, 33'h11);
        wr(`OFS_STATUS, 32'h1);
        wr(`OFS_CTRL, 32'h2);
        wr(`OFS_DOUT, 32'h141);
        pin(19'h341FF);
        rd(`OFS_STATUS, 33'h20);
        u_far.lag = 2;
        u_far.listen(1'b1);
        for (k = 0; k < 50 && srcValid !== 1'b0; k++) @(posedge core_clk);
        pin(19'h041FF);
        rd(`OFS_STATUS, 33'h30);
        wr(`OFS_STATUS, 32'h20);
        rd(`OFS_STATUS, 33'h10);
        endOfTest();
    end
endmodule
